// *** rtl/smr_pkg.sv ***
// Shared constants, types and helpers for the two-wire serial memory slave.
// Assumes a 25 MHz system clock and a link clock taken straight from SCL.
package smr_pkg;

  localparam int          MEM_DEPTH    = 131072;
  localparam logic [16:0] ADDR_RST     = 17'h0_0000;
  localparam logic [16:0] ADDR_MAX     = 17'h1_FFFF;
  localparam logic [3:0]  DEV_TYPE     = 4'hA;
  localparam logic [7:0]  CODE_PRE     = 8'hF8;
  localparam logic [7:0]  CODE_SLEEP   = 8'h86;
  localparam logic [7:0]  CODE_ID      = 8'hF9;
  localparam logic [7:0]  CODE_SN      = 8'hCD;
  localparam logic [3:0]  BIT_FIRST    = 4'h1;
  localparam logic [3:0]  BIT_LAST     = 4'h7;
  localparam logic [3:0]  BIT_ACK      = 4'h8;
  localparam logic [3:0]  BIT_RST      = 4'h0;
  localparam logic [2:0]  IDX_RST      = 3'h0;
  localparam logic [2:0]  ID_LAST      = 3'h2;
  localparam logic [3:0]  DENS_1MB     = 4'h4;
  localparam logic [3:0]  PART_LOW     = 4'h0;
  localparam logic [15:0] CUST_ID_DEF  = 16'h0000;
  localparam logic [7:0]  CRC_POLY     = 8'h07;
  localparam logic [7:0]  CRC_INIT     = 8'h00;
  localparam int          CRC_BYTES    = 7;
  localparam int          WAKE_TIME_US = 400;
  localparam int          CLK_KHZ      = 25000;
  // Longest time, so the cycle count rounds down
  localparam int          WAKE_CYC     = WAKE_TIME_US * CLK_KHZ / 1000;
  localparam logic [15:0] WCNT_RST     = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_TGT, ST_SPEC, ST_WA_HI, ST_WA_LO, ST_WDATA, ST_RD
  } smr_state_t;

  typedef enum logic [1:0] {SRC_MEM, SRC_ID, SRC_SN} smr_src_t;

  typedef struct packed {
    logic start_tgl;
    logic stop_tgl;
  } smr_cond_t;

  function automatic logic [16:0] smr_inc(input logic [16:0] a);
    return (a == ADDR_MAX) ? ADDR_RST : 17'(a + 17'h1);
  endfunction : smr_inc

  // Bitwise form of the table-driven CRC-8, most significant byte first
  function automatic logic [7:0] smr_crc8(input logic [55:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = CRC_BYTES - 1; i >= 0; i--) begin
      c = c ^ d[8*i +: 8];
      for (int b = 0; b < 8; b++) begin
        c = c[7] ? 8'((c << 1) ^ CRC_POLY) : 8'(c << 1);
      end
    end
    return c;
  endfunction : smr_crc8

endpackage : smr_pkg

// *** rtl/smr_cond_det.sv ***
// Start and stop detector for the two-wire link.
// Assumes SDA and SCL are glitch-free; each condition flips a toggle.
`timescale 1ns/1ns
module smr_cond_det import smr_pkg::*; (
  input  wire logic rst,    // Asynchronous clear of both toggles
  input  wire logic scl_i,  // Bus clock level
  input  wire logic sda_i,  // Bus data level
  output smr_cond_t cond    // Start and stop toggles
);

  logic start_r;
  logic start_nxt;
  logic stop_r;
  logic stop_nxt;

  always_comb begin
    start_nxt = scl_i ? ~start_r : start_r;
    stop_nxt  = scl_i ? ~stop_r : stop_r;
  end

  // Falling data while the clock is high marks a start
  always_ff @(negedge sda_i or posedge rst) begin
    if (rst) begin
      start_r <= 1'b0;
    end else begin
      start_r <= start_nxt;
    end
  end

  // Rising data while the clock is high marks a stop
  always_ff @(posedge sda_i or posedge rst) begin
    if (rst) begin
      stop_r <= 1'b0;
    end else begin
      stop_r <= stop_nxt;
    end
  end

  assign cond = '{start_tgl: start_r, stop_tgl: stop_r};

endmodule : smr_cond_det

// *** rtl/smr_top.sv ***
// Two-wire slave of a 128K x 8 serial memory: reads, address load, sleep, ID.
// Assumes SCL is the link clock and an open-drain SDA resolved outside.
//
// What this block does
// - Address byte: type 1010, select, page, R/W
// - Seventeen-bit address latch increments before ack
// - Read address starts shifting current-address data
// - Address counter increments after every sent memory byte
// - Master ack fetches next sequential byte
// - Address wraps from top to zero
// - Repeated start drops write, read is current
// - Preamble target byte acked on upper bits
// - Sleep code acked, stop enters sleep
// - Own address wakes device within recovery time
// - Every address refused until fully awake
// - Identifier code sends manufacturer, part, revision
// - Nack ends identifier read, bus released
// - Part field: density, serial flag, four reserved bits
// - Serial: customer, unique number, CRC byte
// - Serial code streams serial bytes until nack
`timescale 1ns/1ns
module smr_top import smr_pkg::*; #(
  parameter int          WAKE_CYCLES = WAKE_CYC,     // Wake recovery in clk cycles
  parameter logic [11:0] MFG_ID      = 12'h05A,      // Arbitrary value
  parameter logic [2:0]  DIE_REV     = 3'h1,         // Arbitrary value
  parameter logic        HAS_SN      = 1'b1,         // Serial number fitted
  parameter logic [15:0] CUST_ID     = CUST_ID_DEF,  // Customer field
  parameter logic [39:0] UNIQUE_NUM  = 40'h00_1234_5678 // Arbitrary value
) (
  input  wire logic       clk,       // System clock
  input  wire logic       srst,      // Synchronous reset, active high
  input  wire logic       scl_clk,   // Link clock from the bus
  input  wire logic       sda_i,     // Bus data level
  output logic            sda_o,     // Data driven when enabled, always low
  output logic            sda_oe_n,  // Low while pulling SDA low
  input  wire logic [1:0] dev_sel,   // Device select pins
  output logic            sleeping,  // Device in sleep state
  output logic            waking     // Wake recovery in progress
);

  // Link domain
  logic [1:0] lrst_s;
  logic       lrst;
  logic [1:0] dsel_m_r, dsel_s_r;
  logic       nr_m_r, nr_s_r;
  // System-domain readiness, read here through two link-clock flops
  logic       ready_r, ready_nxt;
  smr_cond_t  cond;
  logic       start_seen_r;
  logic       start_pend;

  smr_state_t  st_r, st_nxt;
  smr_src_t    src_r, src_nxt;
  logic [3:0]  bcnt_r, bcnt_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic [7:0]  tx_r, tx_nxt;
  logic [16:0] addr_r, addr_nxt;
  logic [2:0]  idx_r, idx_nxt;
  logic        drive_r, drive_nxt;
  logic        pre_r, pre_nxt;
  logic        usack_r, usack_nxt;
  logic        sreq_r, sreq_nxt;
  logic        wtgl_r, wtgl_nxt;
  logic        we;
  logic [7:0]  rxb;
  logic        own_match;
  logic [7:0]  fetch;
  logic [7:0]  mem_r [0:MEM_DEPTH-1];
  logic        oe_n_r;
  logic        sda_o_r;

  // Identifier and serial vectors, most significant byte first
  localparam logic [8:0]  PART_ID = {DENS_1MB, HAS_SN, PART_LOW};
  localparam logic [63:0] ID_VEC  = {MFG_ID, PART_ID, DIE_REV, 40'h00_0000_0000};
  localparam logic [55:0] SN_BODY = {CUST_ID, UNIQUE_NUM};
  localparam logic [63:0] SN_VEC  = {SN_BODY, smr_crc8(SN_BODY)};

  always_ff @(posedge scl_clk) begin
    lrst_s   <= {lrst_s[0], srst};
    dsel_m_r <= dev_sel;
    dsel_s_r <= dsel_m_r;
    nr_m_r   <= ~ready_r;
    nr_s_r   <= nr_m_r;
  end
  assign lrst = lrst_s[1];

  smr_cond_det u_cond (
    .rst   (srst),
    .scl_i (scl_clk),
    .sda_i (sda_i),
    .cond  (cond)
  );

  assign start_pend = cond.start_tgl != start_seen_r;
  assign rxb        = {sh_r[6:0], sda_i};
  assign own_match  = rxb[7:2] == {DEV_TYPE, dsel_s_r};

  always_comb begin
    unique case (src_r)
      SRC_MEM: fetch = mem_r[addr_r];
      SRC_ID:  fetch = ID_VEC[8*(7-int'(idx_r)) +: 8];
      SRC_SN:  fetch = SN_VEC[8*(7-int'(idx_r)) +: 8];
      default: fetch = 8'h00;
    endcase
  end

  always_comb begin
    st_nxt    = st_r;
    src_nxt   = src_r;
    bcnt_nxt  = (bcnt_r == BIT_ACK) ? BIT_RST : 4'(bcnt_r + 4'h1);
    sh_nxt    = rxb;
    tx_nxt    = tx_r;
    addr_nxt  = addr_r;
    idx_nxt   = idx_r;
    drive_nxt = 1'b0;
    pre_nxt   = pre_r;
    usack_nxt = 1'b0;
    sreq_nxt  = sreq_r;
    wtgl_nxt  = wtgl_r;
    we        = 1'b0;
    if (start_pend) begin
      st_nxt   = ST_ADDR;
      bcnt_nxt = BIT_FIRST;
      sreq_nxt = 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          pre_nxt = 1'b0;
        end
        ST_SPEC: begin
          drive_nxt = 1'b0;
        end
        ST_ADDR: begin
          if (bcnt_r == BIT_LAST) begin
            pre_nxt   = 1'b0;
            usack_nxt = 1'b1;
            st_nxt    = ST_IDLE;
            if (rxb == CODE_PRE && nr_s_r == 1'b0) begin
              drive_nxt = 1'b1;
              st_nxt    = ST_TGT;
            end else if (pre_r && rxb == CODE_SLEEP) begin
              drive_nxt = 1'b1;
              sreq_nxt  = 1'b1;
            end else if (pre_r && rxb == CODE_ID) begin
              drive_nxt = 1'b1;
              st_nxt    = ST_RD;
              src_nxt   = SRC_ID;
              idx_nxt   = IDX_RST;
            end else if (pre_r && rxb == CODE_SN && HAS_SN) begin
              drive_nxt = 1'b1;
              st_nxt    = ST_RD;
              src_nxt   = SRC_SN;
              idx_nxt   = IDX_RST;
            end else if (own_match && nr_s_r) begin
              wtgl_nxt = ~wtgl_r;
            end else if (own_match) begin
              drive_nxt = 1'b1;
              src_nxt   = SRC_MEM;
              if (rxb[0]) begin
                st_nxt = ST_RD;
              end else begin
                st_nxt   = ST_WA_HI;
                addr_nxt = {rxb[1], addr_r[15:0]};
              end
            end
          end
        end
        ST_TGT: begin
          if (bcnt_r == BIT_LAST) begin
            drive_nxt = own_match;
            pre_nxt   = own_match;
            st_nxt    = own_match ? ST_SPEC : ST_IDLE;
          end
        end
        ST_WA_HI: begin
          if (bcnt_r == BIT_LAST) begin
            drive_nxt = 1'b1;
            addr_nxt  = {addr_r[16], rxb, addr_r[7:0]};
            st_nxt    = ST_WA_LO;
          end
        end
        ST_WA_LO: begin
          if (bcnt_r == BIT_LAST) begin
            drive_nxt = 1'b1;
            addr_nxt  = {addr_r[16:8], rxb};
            st_nxt    = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (bcnt_r == BIT_LAST) begin
            drive_nxt = 1'b1;
            we        = 1'b1;
            addr_nxt  = smr_inc(addr_r);
          end
        end
        ST_RD: begin
          if (bcnt_r == BIT_ACK) begin
            if (usack_r || !sda_i) begin
              tx_nxt    = fetch;
              drive_nxt = ~fetch[7];
            end else begin
              st_nxt = ST_IDLE;
            end
          end else if (bcnt_r == BIT_LAST) begin
            if (src_r == SRC_MEM) begin
              addr_nxt = smr_inc(addr_r);
            end else if (src_r == SRC_ID && idx_r == ID_LAST) begin
              idx_nxt = IDX_RST;
            end else begin
              idx_nxt = 3'(idx_r + 3'h1);
            end
          end else begin
            tx_nxt    = {tx_r[6:0], 1'b0};
            drive_nxt = ~tx_r[6];
          end
        end
      endcase
    end
  end

  always_ff @(posedge scl_clk) begin
    if (lrst) begin
      st_r         <= ST_IDLE;
      src_r        <= SRC_MEM;
      bcnt_r       <= BIT_RST;
      sh_r         <= 8'h00;
      tx_r         <= 8'h00;
      addr_r       <= ADDR_RST;
      idx_r        <= IDX_RST;
      drive_r      <= 1'b0;
      pre_r        <= 1'b0;
      usack_r      <= 1'b0;
      sreq_r       <= 1'b0;
      wtgl_r       <= 1'b0;
      start_seen_r <= cond.start_tgl;
    end else begin
      st_r         <= st_nxt;
      src_r        <= src_nxt;
      bcnt_r       <= bcnt_nxt;
      sh_r         <= sh_nxt;
      tx_r         <= tx_nxt;
      addr_r       <= addr_nxt;
      idx_r        <= idx_nxt;
      drive_r      <= drive_nxt;
      pre_r        <= pre_nxt;
      usack_r      <= usack_nxt;
      sreq_r       <= sreq_nxt;
      wtgl_r       <= wtgl_nxt;
      start_seen_r <= cond.start_tgl;
    end
  end

  always_ff @(posedge scl_clk) begin
    if (we) begin
      mem_r[addr_r] <= rxb;
    end
  end

  // SDA changes only while SCL is low
  always_ff @(negedge scl_clk) begin
    if (lrst) begin
      oe_n_r  <= 1'b1;
      sda_o_r <= 1'b0;
    end else begin
      oe_n_r  <= ~drive_r;
      sda_o_r <= 1'b0;
    end
  end
  assign sda_oe_n = oe_n_r;
  assign sda_o    = sda_o_r;

  // System domain: sleep and wake recovery
  logic [2:0]  stop_s, wake_s;
  logic [1:0]  sreq_s;
  logic        stop_ev, wake_ev;
  logic        asleep_r, asleep_nxt;
  logic        busy_r, busy_nxt;
  logic [15:0] wcnt_r, wcnt_nxt;

  always_ff @(posedge clk) begin
    stop_s <= {stop_s[1:0], cond.stop_tgl};
    wake_s <= {wake_s[1:0], wtgl_r};
    sreq_s <= {sreq_s[0], sreq_r};
  end
  assign stop_ev = stop_s[2] ^ stop_s[1];
  assign wake_ev = wake_s[2] ^ wake_s[1];

  always_comb begin
    asleep_nxt = asleep_r;
    busy_nxt   = busy_r;
    wcnt_nxt   = wcnt_r;
    if (asleep_r && wake_ev) begin
      asleep_nxt = 1'b0;
      busy_nxt   = 1'b1;
      wcnt_nxt   = 16'(WAKE_CYCLES - 1);
    end else if (busy_r) begin
      busy_nxt = wcnt_r != WCNT_RST;
      wcnt_nxt = (wcnt_r == WCNT_RST) ? WCNT_RST : 16'(wcnt_r - 16'h1);
    end else if (stop_ev && sreq_s[1]) begin
      asleep_nxt = 1'b1;
    end
    ready_nxt = ~(asleep_nxt | busy_nxt);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      asleep_r <= 1'b0;
      busy_r   <= 1'b0;
      ready_r  <= 1'b1;
      wcnt_r   <= WCNT_RST;
    end else begin
      asleep_r <= asleep_nxt;
      busy_r   <= busy_nxt;
      ready_r  <= ready_nxt;
      wcnt_r   <= wcnt_nxt;
    end
  end
  assign sleeping = asleep_r;
  assign waking   = busy_r;

  property p_rd_inc;
    @(posedge scl_clk) disable iff (lrst)
    st_r == ST_RD && !start_pend && bcnt_r == BIT_LAST && src_r == SRC_MEM
      |=> addr_r == smr_inc($past(addr_r));
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("address not advanced");

  property p_wrap;
    @(posedge scl_clk) disable iff (lrst)
    st_r == ST_RD && !start_pend && bcnt_r == BIT_LAST && src_r == SRC_MEM
      && addr_r == ADDR_MAX |=> addr_r == ADDR_RST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("address did not wrap");

  property p_rd_ack;
    @(posedge scl_clk) disable iff (lrst)
    st_r == ST_ADDR && !start_pend && bcnt_r == BIT_LAST && own_match && rxb[0]
      && !nr_s_r && !pre_r |=> drive_r && st_r == ST_RD ##1 !start_pend |-> tx_r == $past(fetch);
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read not started");

  property p_next;
    @(posedge scl_clk) disable iff (lrst)
    st_r == ST_RD && !start_pend && bcnt_r == BIT_ACK && !sda_i
      |=> st_r == ST_RD && bcnt_r == BIT_RST && drive_r == ~tx_r[7];
  endproperty
  a_next: assert property (p_next) else $error("next byte not sent");

  property p_nack_end;
    @(posedge scl_clk) disable iff (lrst)
    st_r == ST_RD && !start_pend && bcnt_r == BIT_ACK && sda_i && !usack_r
      |=> st_r == ST_IDLE ##1 oe_n_r;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("bus not released");

  property p_start_rel;
    @(posedge scl_clk) disable iff (lrst)
    start_pend |=> !drive_r && st_r == ST_ADDR && bcnt_r == BIT_FIRST;
  endproperty
  a_start_rel: assert property (p_start_rel) else $error("start not obeyed");

  property p_tgt_miss;
    @(posedge scl_clk) disable iff (lrst)
    st_r == ST_TGT && !start_pend && bcnt_r == BIT_LAST && !own_match
      |=> !drive_r && st_r == ST_IDLE;
  endproperty
  a_tgt_miss: assert property (p_tgt_miss) else $error("target miss acked");

  property p_refuse;
    @(posedge scl_clk) disable iff (lrst)
    st_r == ST_ADDR && !start_pend && bcnt_r == BIT_LAST && own_match && nr_s_r
      && !pre_r |=> !drive_r;
  endproperty
  a_refuse: assert property (p_refuse) else $error("acked while not ready");

  property p_sleep;
    @(posedge clk) disable iff (srst)
    stop_ev && sreq_s[1] && !busy_r && !(asleep_r && wake_ev) |=> asleep_r && !ready_r;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");

  property p_wake;
    @(posedge clk) disable iff (srst)
    busy_r && wcnt_r == WCNT_RST |=> !busy_r && ready_r;
  endproperty
  a_wake: assert property (p_wake) else $error("wake recovery overran");

endmodule : smr_top

// *** tb/smr_mst.sv ***
// Behavioural two-wire bus master: drives SCL and its side of SDA.
// Assumes a pull-up on SDA, so the wire is the AND of all drivers.
`timescale 1ns/1ns
module smr_mst (
  output logic      scl,    // Link clock, high and still between frames
  output logic      sda_m,  // Master drive level, 1 means released
  input  wire logic sda_w   // Resolved SDA wire
);
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // Bare pulses with SDA released, used only before the first frame
  task automatic pulses(input int n);
    repeat (n) begin
      #63 scl = 1'b0;
      #62 scl = 1'b1;
    end
  endtask : pulses

  task automatic bus_start();
    #31 sda_m = 1'b1;
    #32 scl = 1'b1;
    #31 sda_m = 1'b0;
    #31 scl = 1'b0;
  endtask : bus_start

  task automatic bus_stop();
    #31 sda_m = 1'b0;
    #32 scl = 1'b1;
    #31 sda_m = 1'b1;
    #31;
  endtask : bus_stop

  // Data changes mid low phase; the wire is taken at the rising edge
  task automatic bit_x(input logic b, output logic r);
    #31 sda_m = b;
    #32 scl = 1'b1;
    r = sda_w;
    #62 scl = 1'b0;
  endtask : bit_x

  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic a_in,
                      output logic [7:0] q, output logic a_out);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(a_in, a_out);
  endtask : xfer
endmodule : smr_mst

// *** tb/tb_top.sv ***
// Self-checking bench for the memory slave: reads, ID, serial number, sleep.
// Assumes the master model smr_mst and a pull-up on SDA.
`timescale 1ns/1ns
module tb_top;
  import smr_pkg::*;
  localparam logic [1:0]  SEL  = 2'b10;
  localparam logic [11:0] MFG  = 12'h05A;          // Arbitrary value
  localparam logic [2:0]  DREV = 3'h5;             // Arbitrary value
  localparam logic [39:0] UNUM = 40'hA5_0F3C_9617; // Arbitrary value
  localparam int          WAKE = 100;

  logic       clk, srst, scl, sda_m, sda_w, sda_o, sda_oe_n, sleeping, waking;
  logic [1:0] dev_sel;
  logic [7:0] wdat [4] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4};
  logic [23:0] idv;
  logic [63:0] snv;
  int         num_errors, check_count, wake_cnt;
  int         cyc = 0;

  assign sda_w = sda_m & (sda_oe_n | sda_o);

  smr_top #(.WAKE_CYCLES(WAKE), .MFG_ID(MFG), .DIE_REV(DREV), .UNIQUE_NUM(UNUM)) smr_top_inst (
    .clk(clk), .srst(srst), .scl_clk(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .dev_sel(dev_sel), .sleeping(sleeping), .waking(waking));
  smr_mst smr_mst_inst (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard well above the roughly 1500 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (waking === 1'b1) wake_cnt <= wake_cnt + 1;
    if (cyc == 20000) begin
      num_errors++;
      $display("ERROR timeout expected end seen hang");
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte

  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_byte(n, {7'h00, e}, {7'h00, g});
  endtask : chk_bit

  function automatic logic [7:0] adr(input logic pg, input logic rd);
    return {4'hA, SEL, pg, rd};
  endfunction : adr

  // Bit-serial CRC-8, poly 07, zero start
  function automatic logic [7:0] crc_ref(input logic [55:0] d);
    logic [7:0] c = 8'h00;
    for (int i = 55; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc_ref

  task automatic send(input logic [7:0] d, input logic exp_n);
    logic [7:0] q;
    logic       a;
    smr_mst_inst.xfer(d, 1'b1, q, a);
    chk_bit("slave_ack_n", exp_n, a);
  endtask : send

  task automatic recv(input logic [7:0] exp, input logic mack_n);
    logic [7:0] q;
    logic       a;
    smr_mst_inst.xfer(8'hFF, mack_n, q, a);
    chk_byte("read_data", exp, q);
  endtask : recv

  task automatic special(input logic [7:0] tgt, input logic tgt_n,
                         input logic [7:0] code, input logic code_n);
    smr_mst_inst.bus_start();
    send(8'hF8, 1'b0);
    send(tgt, tgt_n);
    smr_mst_inst.bus_start();
    send(code, code_n);
  endtask : special

  task automatic wait_flag(input logic wk, input logic v);
    int n = 0;
    while (((wk ? waking : sleeping) !== v) && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk_bit(wk ? "waking" : "sleeping", v, wk ? waking : sleeping);
  endtask : wait_flag

  task automatic release_check();
    #10;
    chk_bit("sda_oe_n", 1'b1, sda_oe_n);
    smr_mst_inst.bus_stop();
  endtask : release_check

  initial begin
    logic [7:0] q;
    logic       ack;
    int         tries;
    srst = 1'b1;
    dev_sel = SEL;
    num_errors = 0;
    check_count = 0;
    wake_cnt = 0;
    idv = {MFG, 4'h4, 1'b1, 4'h0, DREV};
    snv = {16'h0000, UNUM, crc_ref({16'h0000, UNUM})};
    // Link logic needs SCL edges while reset is held
    smr_mst_inst.pulses(3);
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    // Link reset leaves only after two more SCL rises
    smr_mst_inst.pulses(3);

    smr_mst_inst.bus_start();
    send({4'hA, ~SEL, 2'b00}, 1'b1);
    smr_mst_inst.bus_stop();
    smr_mst_inst.bus_start();
    send({4'hB, SEL, 2'b00}, 1'b1);
    smr_mst_inst.bus_stop();
    $display("test address match done");

    smr_mst_inst.bus_start();
    send(adr(1'b1, 1'b0), 1'b0);
    send(8'hFF, 1'b0);
    send(8'hFE, 1'b0);
    foreach (wdat[i]) send(wdat[i], 1'b0);
    smr_mst_inst.bus_stop();
    smr_mst_inst.bus_start();
    send(adr(1'b1, 1'b0), 1'b0);
    send(8'hFF, 1'b0);
    send(8'hFF, 1'b0);
    smr_mst_inst.bus_start();
    send(adr(1'b1, 1'b1), 1'b0);
    recv(wdat[1], 1'b0);
    recv(wdat[2], 1'b1);
    smr_mst_inst.bus_start();
    send(adr(1'b0, 1'b1), 1'b0);
    recv(wdat[3], 1'b1);
    release_check();
    $display("test memory read done");

    special(adr(1'b1, 1'b1), 1'b0, 8'hF9, 1'b0);
    for (int i = 2; i >= 0; i--) recv(idv[8*i +: 8], i == 0);
    release_check();
    special(adr(1'b0, 1'b0), 1'b0, 8'hF9, 1'b0);
    recv(idv[23:16], 1'b1);
    release_check();
    $display("test device id done");

    special(adr(1'b0, 1'b1), 1'b0, 8'hCD, 1'b0);
    for (int i = 7; i >= 0; i--) recv(snv[8*i +: 8], i == 0);
    release_check();
    special({4'hA, ~SEL, 2'b11}, 1'b1, 8'hF9, 1'b1);
    smr_mst_inst.bus_stop();
    $display("test serial number done");

    special(adr(1'b0, 1'b0), 1'b0, 8'h86, 1'b0);
    smr_mst_inst.bus_stop();
    wait_flag(1'b0, 1'b1);
    smr_mst_inst.bus_start();
    send(adr(1'b0, 1'b0), 1'b1);
    smr_mst_inst.bus_stop();
    wait_flag(1'b1, 1'b1);
    chk_bit("sleeping", 1'b0, sleeping);
    tries = 0;
    ack = 1'b1;
    // Poll until the device answers again
    while (ack !== 1'b0 && tries < 8) begin
      smr_mst_inst.bus_start();
      // A write poll leaves SDA free for the stop once acked
      smr_mst_inst.xfer(adr(1'b0, 1'b0), 1'b1, q, ack);
      smr_mst_inst.bus_stop();
      tries++;
      if (ack === 1'b0) chk_bit("waking", 1'b0, waking);
    end
    chk_bit("poll_nacked", 1'b1, tries > 1);
    chk_bit("woken_ack_n", 1'b0, ack);
    chk_byte("wake_cycles", 8'(WAKE), 8'(wake_cnt));
    $display("test sleep done");
    print_verdict();
  end
endmodule : tb_top
